// ==== src/asp_pkg.sv ====
/*
 * asp_pkg: constants, state types and register layout of the
 * asynchronous serial port with its baud timer.
 * assumes: one system clock, AHB-Lite register access.
 */
`default_nettype none
package asp_pkg;
	// ==========================================================
	// register offsets (byte addresses, low address byte)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_BAUD = 8'h08;
	localparam logic [7:0] OFS_ISTAT = 8'h0c;
	localparam logic [7:0] OFS_IMASK = 8'h10;

	// ==========================================================
	// serial_control_reg bit positions
	localparam int CTL_MODE9 = 7;
	localparam int CTL_ONE = 6;
	localparam int CTL_MCE = 5;
	localparam int CTL_REN = 4;
	localparam int CTL_TB8 = 3;
	localparam int CTL_RB8 = 2;
	localparam int CTL_TI = 1;
	localparam int CTL_RI = 0;

	// ==========================================================
	// baud control register fields
	localparam int BD_EN = 0;
	localparam int BD_SEL_LSB = 1;
	localparam int BD_RELOAD_LSB = 8;
	localparam int BD_COUNT_LSB = 16;

	// count clock sources
	localparam logic [2:0] SEL_SYS = 3'h0;
	localparam logic [2:0] SEL_DIV4 = 3'h1;
	localparam logic [2:0] SEL_DIV12 = 3'h2;
	localparam logic [2:0] SEL_DIV48 = 3'h3;
	localparam logic [2:0] SEL_OSC8 = 3'h4;
	localparam logic [2:0] SEL_PIN = 3'h5;

	// interrupt status and mask bits
	localparam int IRQ_RX = 0;
	localparam int IRQ_TX = 1;

	// ==========================================================
	// prescaler and frame counts
	localparam logic [3:0] PRE12_LAST = 4'hb;
	localparam logic [1:0] Q4_LAST = 2'h3;
	localparam logic [2:0] OSC_LAST = 3'h7;
	localparam logic [7:0] TMR_TOP = 8'hff;
	localparam logic [3:0] TX_LEN8 = 4'ha;
	localparam logic [3:0] TX_LEN9 = 4'hb;
	localparam logic [3:0] RX_LAST8 = 4'h9;
	localparam logic [3:0] RX_LAST9 = 4'ha;

	// reset values
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [2:0] SEL_RST = 3'h0;

	// ==========================================================
	// state types
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_WAIT = 3'b010,
		TX_SEND = 3'b100
	} asp_tx_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_RUN = 2'b10
	} asp_rx_t;

	typedef struct packed {
		logic [7:0] count;
	} asp_tmr_state_t;

	typedef struct packed {
		logic mode9;
		logic mce;
		logic ren;
		logic tb8;
		logic rb8;
		logic ti;
		logic ri;
		logic baud_en;
		logic [2:0] clk_sel;
		logic [7:0] reload;
		logic [1:0] istat;
		logic [1:0] imask;
		logic irq;
		logic [7:0] rx_buf;
		logic dp_wr;
		logic dp_rd;
		logic [7:0] dp_addr;
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		logic [3:0] pre12;
		logic [1:0] q4;
		logic [2:0] osc_div;
		logic osc_prev;
		logic pin_prev;
		asp_tx_t tx_state;
		logic tx_half;
		logic [10:0] tx_shift;
		logic [3:0] tx_left;
		logic [7:0] tx_data;
		logic txd;
		asp_rx_t rx_state;
		logic rx_half;
		logic [3:0] rx_cnt;
		logic [9:0] rx_bits;
		logic rxd_prev;
	} asp_state_t;
endpackage : asp_pkg
`default_nettype wire

// ==== src/asp_tmr_if.sv ====
/*
 * asp_tmr_if: link between the port logic and one baud timer copy.
 * assumes: driven and read in the clk domain only.
 */
`timescale 1ns/10ps
`default_nettype none
interface asp_tmr_if;
	logic tick;
	logic force_reload;
	logic [7:0] reload;
	logic [7:0] count;
	logic overflow;
	modport timer(input tick, input force_reload, input reload, output count, output overflow);
	modport user(output tick, output force_reload, output reload, input count, input overflow);
endinterface : asp_tmr_if
`default_nettype wire

// ==== src/asp_baud_timer.sv ====
/*
 * asp_baud_timer: 8-bit auto-reload counter with overflow pulse.
 * assumes: tick is a one-cycle count enable; force wins over tick.
 */
`timescale 1ns/10ps
`default_nettype none
module asp_baud_timer (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// timer link
	asp_tmr_if.timer tif
);
	import asp_pkg::*;

	asp_tmr_state_t s;
	asp_tmr_state_t next_s;

	// ==========================================================
	// count, reload on overflow or on force
	always_comb begin
		next_s = s;
		if (tif.force_reload) begin
			next_s.count = tif.reload;
		end else if (tif.tick) begin
			if (s.count == TMR_TOP) begin
				next_s.count = tif.reload;
			end else begin
				next_s.count = s.count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// outputs to the user side
	assign tif.count = s.count;
	assign tif.overflow = tif.tick && !tif.force_reload && (s.count == TMR_TOP);
endmodule : asp_baud_timer
`default_nettype wire

// ==== src/asp_serial_port.sv ====
/*
 * asp_serial_port: full duplex asynchronous serial port with baud
 * timer, AHB-Lite register slave and masked interrupt.
 * assumes: all inputs synchronous to clk, single zero/one-wait slave.
 */
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
// Behaviour
// - asynchronous full duplex port, 8-bit and 9-bit variable-rate framings only
// - completed byte held in buffer while next byte shifts in
// - write to data buffer loads transmit register and starts sending
// - read of data buffer returns receive buffer; transmit data unreadable
// - interrupt requested when enabled and transmit-done or receive-done set; code raises it from the ISTAT bits, cleared by an ISTAT read, not from ti/ri
// - done flags cleared only by software write, never by hardware
// - bit clock from 8-bit auto-reload timer low count overflows
// - receive clock from a hidden copy of the low counter
// - both timer overflow streams halved to give bit rates
// - receive timer counts when timer enabled, same reload byte
// - start edge on receive pin forces receive timer reload
// - timer count clock from six selectable sources
// - 8-bit frame: start, eight data LSB first, stop into ninth field
// - 9-bit frame: start, data, ninth bit, stop; stop ignored on receive
// - transmit-done set at start of stop bit time
// - load and flag only if flag clear and filter condition holds
`timescale 1ns/10ps
`default_nettype none
module asp_serial_port (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// serial lines
	input wire logic rxd,
	output logic txd,
	// timer clock inputs
	input wire logic ext_osc_clk,
	input wire logic baud_timer_ext_input,
	// interrupt
	output logic irq
);
	import asp_pkg::*;

	asp_state_t s;
	asp_state_t next_s;
	logic count_tick;
	logic rx_force;
	logic tx_bit;
	logic rx_fall;
	logic accept;
	logic wr_data;
	logic rx_b8;
	logic [3:0] rx_idx;
	logic [3:0] rx_last;

	asp_tmr_if tx_tif ();
	asp_tmr_if rx_tif ();

	// ==========================================================
	// timer copies: transmit and hidden receive
	asp_baud_timer u_tx_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.tif(tx_tif)
	);

	// the receive copy shows in no register, so software cannot reach it
	asp_baud_timer u_rx_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.tif(rx_tif)
	);

	// shared tick and reload, forced reload only on receive copy
	assign tx_tif.tick = count_tick;
	assign rx_tif.tick = count_tick;
	assign tx_tif.reload = s.reload;
	assign rx_tif.reload = s.reload;
	assign tx_tif.force_reload = 1'b0;
	assign rx_tif.force_reload = rx_force;

	// ==========================================================
	// count clock select; kept out of the main process so the
	// overflow fed back from the timers closes no process loop
	always_comb begin
		count_tick = 1'b0;
		case (s.clk_sel)
			SEL_SYS: count_tick = 1'b1;
			SEL_DIV4: count_tick = (s.pre12[1:0] == Q4_LAST);
			SEL_DIV12: count_tick = (s.pre12 == PRE12_LAST);
			SEL_DIV48: count_tick = (s.pre12 == PRE12_LAST) && (s.q4 == Q4_LAST);
			SEL_OSC8: count_tick = ext_osc_clk && !s.osc_prev && (s.osc_div == OSC_LAST);
			SEL_PIN: count_tick = !baud_timer_ext_input && s.pin_prev;
			default: count_tick = 1'b0;
		endcase
		count_tick = count_tick && s.baud_en;
	end

	// start edge on the receive pin forces the hidden timer reload
	assign rx_fall = s.rxd_prev && !rxd;
	assign rx_force = (s.rx_state == RX_IDLE) && s.ren && s.baud_en && rx_fall;

	// ==========================================================
	// next state
	always_comb begin
		next_s = s;
		rx_b8 = 1'b0;
		rx_idx = 4'h0;
		rx_last = s.mode9 ? RX_LAST9 : RX_LAST8;
		accept = hsel && htrans[1] && hready;
		wr_data = s.dp_wr && (s.dp_addr == OFS_DATA);

		// prescalers for the count clock
		// one free /12 counter also gives the /4 tap and, with q4, /48
		next_s.pre12 = (s.pre12 == PRE12_LAST) ? 4'h0 : s.pre12 + 4'h1;
		if (s.pre12 == PRE12_LAST) begin
			next_s.q4 = s.q4 + 2'h1;
		end
		next_s.osc_prev = ext_osc_clk;
		next_s.pin_prev = baud_timer_ext_input;
		if (ext_osc_clk && !s.osc_prev) begin
			next_s.osc_div = s.osc_div + 3'h1;
		end

		// ahb address phase: writes zero wait, reads one wait
		// hsize is not decoded: every register is one aligned word
		next_s.dp_wr = accept && hwrite;
		next_s.dp_rd = accept && !hwrite;
		next_s.hresp = 1'b0;
		if (accept) begin
			next_s.dp_addr = haddr[7:0];
		end
		next_s.hreadyout = !(accept && !hwrite);

		// read data phase
		if (s.dp_rd) begin
			case (s.dp_addr)
				OFS_CTRL: next_s.hrdata = {24'h000000, s.mode9, 1'b1, s.mce, s.ren,
					s.tb8, s.rb8, s.ti, s.ri};
				OFS_DATA: next_s.hrdata = {24'h000000, s.rx_buf};
				OFS_BAUD: next_s.hrdata = {8'h00, tx_tif.count, s.reload, 4'h0,
					s.clk_sel, s.baud_en};
				OFS_ISTAT: next_s.hrdata = {30'h0, s.istat};
				OFS_IMASK: next_s.hrdata = {30'h0, s.imask};
				default: next_s.hrdata = 32'h00000000;
			endcase
			// read clears status; an event this cycle is set again below
			if (s.dp_addr == OFS_ISTAT) begin
				next_s.istat = 2'h0;
			end
		end

		// write data phase
		// flags written as zero clear; a hardware set below still wins
		if (s.dp_wr) begin
			case (s.dp_addr)
				OFS_CTRL: begin
					next_s.mode9 = hwdata[CTL_MODE9];
					next_s.mce = hwdata[CTL_MCE];
					next_s.ren = hwdata[CTL_REN];
					next_s.tb8 = hwdata[CTL_TB8];
					next_s.rb8 = hwdata[CTL_RB8];
					next_s.ti = hwdata[CTL_TI];
					next_s.ri = hwdata[CTL_RI];
				end
				OFS_DATA: begin
					next_s.tx_data = hwdata[7:0];
					next_s.tx_state = TX_WAIT;
				end
				OFS_BAUD: begin
					next_s.baud_en = hwdata[BD_EN];
					next_s.clk_sel = hwdata[BD_SEL_LSB +: 3];
					next_s.reload = hwdata[BD_RELOAD_LSB +: 8];
				end
				OFS_IMASK: next_s.imask = hwdata[1:0];
				default: begin
				end
			endcase
		end

		// transmitter: halved overflow gives the bit clock
		tx_bit = tx_tif.overflow && s.tx_half;
		if (tx_tif.overflow) begin
			next_s.tx_half = !s.tx_half;
		end
		// a data write owns this cycle and restarts the frame
		if (!wr_data) begin
			case (s.tx_state)
				TX_IDLE: next_s.txd = 1'b1;
				TX_WAIT: begin
					if (tx_bit) begin
						if (s.mode9) begin
							next_s.tx_shift = {1'b1, s.tb8, s.tx_data, 1'b0};
							next_s.tx_left = TX_LEN9 - 4'h1;
						end else begin
							next_s.tx_shift = {2'b11, s.tx_data, 1'b0};
							next_s.tx_left = TX_LEN8 - 4'h1;
						end
						next_s.txd = 1'b0;
						next_s.tx_state = TX_SEND;
					end
				end
				TX_SEND: begin
					if (tx_bit) begin
						if (s.tx_left == 4'h0) begin
							next_s.tx_state = TX_IDLE;
						end else begin
							next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
							next_s.txd = s.tx_shift[1];
							next_s.tx_left = s.tx_left - 4'h1;
						end
						if (s.tx_left == 4'h1) begin
							next_s.ti = 1'b1;
							next_s.istat[IRQ_TX] = 1'b1;
						end
					end
				end
				default: next_s.tx_state = TX_IDLE;
			endcase
		end

		// receiver: start edge aligns the hidden timer
		// overflows 1, 3, 5 .. sample start, data, ninth and stop
		next_s.rxd_prev = rxd;
		rx_idx = s.rx_cnt - 4'h1;
		case (s.rx_state)
			RX_IDLE: begin
				if (rx_force) begin
					next_s.rx_half = 1'b0;
					next_s.rx_cnt = 4'h0;
					next_s.rx_state = RX_RUN;
				end
			end
			RX_RUN: begin
				if (!s.ren) begin
					next_s.rx_state = RX_IDLE;
				end else if (rx_tif.overflow) begin
					next_s.rx_half = !s.rx_half;
					if (!s.rx_half) begin
						next_s.rx_cnt = s.rx_cnt + 4'h1;
						if (s.rx_cnt == 4'h0) begin
							if (rxd) begin
								next_s.rx_state = RX_IDLE;
							end
						end else if (s.rx_cnt == rx_last) begin
							rx_b8 = s.mode9 ? s.rx_bits[8] : rxd;
							if (!s.ri && (!s.mce || rx_b8)) begin
								next_s.rx_buf = s.rx_bits[7:0];
								next_s.rb8 = rx_b8;
								next_s.ri = 1'b1;
								next_s.istat[IRQ_RX] = 1'b1;
							end
							next_s.rx_state = RX_IDLE;
						end else begin
							next_s.rx_bits[rx_idx] = rxd;
						end
					end
				end
			end
			default: next_s.rx_state = RX_IDLE;
		endcase

		// masked interrupt level
		next_s.irq = |(next_s.istat & next_s.imask);
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s <= '0;
			s.reload <= RELOAD_RST;
			s.clk_sel <= SEL_RST;
			s.hreadyout <= 1'b1;
			s.txd <= 1'b1;
			// edge detectors start at idle level: no false edge
			s.osc_prev <= 1'b1;
			s.pin_prev <= 1'b1;
			s.rxd_prev <= 1'b1;
			s.tx_state <= TX_IDLE;
			s.rx_state <= RX_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state register
	assign hreadyout = s.hreadyout;
	assign hresp = s.hresp;
	assign hrdata = s.hrdata;
	assign txd = s.txd;
	assign irq = s.irq;
endmodule : asp_serial_port
`default_nettype wire

// ==== testbench/asp_serial_port_chk.sv ====
/* port checks of asp_serial_port: bus timing, serial line, reset.
   assumes: one clock domain, bound to the top module. */
`timescale 1ns/10ps
`default_nettype none
module asp_serial_port_chk (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// serial and interrupt
	input wire logic txd,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// accepted requests
	logic rd_take;
	logic wr_take;
	assign rd_take = hsel && htrans[1] && hready && !hwrite;
	assign wr_take = hsel && htrans[1] && hready && hwrite;
	// ==========================================================
	// assertions
	a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (wr_take |=> hreadyout)
		else $error("write stalled");
	a_wait_cause: assert property (!hreadyout |-> $past(rd_take))
		else $error("wait state without read");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response");
	a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
		else $error("read data moved outside a read");
	a_rdata_upper: assert property (hreadyout && !$past(hreadyout) |-> hrdata[31:24] == 8'h00)
		else $error("upper read bits set");
	a_bit_min: assert property ($changed(txd) |=> $stable(txd))
		else $error("serial bit shorter than two cycles");
	a_rst_quiet: assert property (disable iff (1'b0) sys_rst |=> txd && !irq && hreadyout)
		else $error("outputs not idle in reset");
	// covers
	c_read: cover property (rd_take);
	c_tx_start: cover property ($fell(txd));
	c_irq: cover property ($rose(irq));
endmodule : asp_serial_port_chk
bind asp_serial_port asp_serial_port_chk u_chk (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .txd(txd), .irq(irq));
`default_nettype wire

// ==== testbench/asp_far_end.sv ====
/* asp_far_end: remote serial transceiver sending and catching frames.
   assumes: line idles high, bit time given in clk cycles. */
`timescale 1ns/10ps
`default_nettype none
module asp_far_end #(parameter int BIT_CYC = 64) (
	// clock and serial lines
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	initial rxd = 1'b1;
	// start bit, nb bits lsb first, line back to idle
	task send(input logic [10:0] bits, input int nb);
		rxd <= 1'b0;
		repeat (BIT_CYC) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			rxd <= bits[i];
			repeat (BIT_CYC) @(posedge clk);
		end
		rxd <= 1'b1;
		repeat (BIT_CYC) @(posedge clk);
	endtask : send
	// sample nb bits after the start bit at bit centres
	task catch(output logic [10:0] bits, input int nb);
		bits = '0;
		@(posedge clk iff !txd);
		repeat (BIT_CYC / 2) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			repeat (BIT_CYC) @(posedge clk);
			bits[i] = txd;
		end
	endtask : catch
endmodule : asp_far_end
`default_nettype wire

// ==== testbench/async_serial_port_baud_gen_test.sv ====
/* async_serial_port_baud_gen_test: register level tests of the port.
   assumes: asp_pkg compiled, checker bound, far end model present. */
`timescale 1ns/10ps
`default_nettype none
module async_serial_port_baud_gen_test;
	import asp_pkg::*;
	localparam logic [7:0] RL = 8'he0;
	localparam int BIT = 2 * (256 - int'(RL));
	logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, rxd, txd, osc, pin, irq;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [10:0] got;
	int num_errors, check_count, cycles;
	asp_serial_port u_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd),
		.ext_osc_clk(osc), .baud_timer_ext_input(pin), .irq(irq));
	asp_far_end #(.BIT_CYC(BIT)) u_far (.clk(clk), .txd(txd), .rxd(rxd));
	// ==========================================================
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			end_of_test();
		end
	end
	// ==========================================================
	// bus and compare tasks
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge clk iff hreadyout);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk iff hreadyout);
		q = hrdata;
	endtask : xfer
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(name, e, q);
	endtask : rd
	task automatic chk_irq(input logic e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask : chk_irq
	task automatic ext_edges(input logic use_pin, input int n);
		repeat (n) begin
			if (use_pin) pin <= 1'b0; else osc <= 1'b1;
			repeat (2) @(posedge clk);
			if (use_pin) pin <= 1'b1; else osc <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask : ext_edges
	// count snapshots 48 cycles apart give ticks per 48 cycles
	task automatic rate(input logic [2:0] sel, input logic [7:0] e);
		logic [7:0] c0;
		xfer(1'b1, OFS_BAUD, {28'h0, sel, 1'b1});
		xfer(1'b0, OFS_BAUD, 32'h0);
		c0 = q[23:16];
		repeat (44) @(posedge clk);
		xfer(1'b0, OFS_BAUD, 32'h0);
		chk("tick rate", {24'h0, e}, {24'h0, q[23:16] - c0});
	endtask : rate
	task end_of_test();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	// ==========================================================
	// test sequence
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, osc} = '0;
		hsize = 3'h2;
		pin = 1'b1;
		sys_rst = 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd("control", OFS_CTRL, 32'h40);
		rd("unmapped", 8'h20, 32'h0);
		rd("data", OFS_DATA, 32'h0);
		$display("test reset done");
		xfer(1'b1, OFS_BAUD, 32'h0b);
		ext_edges(1'b1, 3);
		rd("pin count", OFS_BAUD, 32'h0003000b);
		xfer(1'b1, OFS_BAUD, 32'h09);
		ext_edges(1'b0, 16);
		rd("osc count", OFS_BAUD, 32'h00050009);
		rate(SEL_DIV4, 8'h0c);
		rate(SEL_DIV12, 8'h04);
		rate(SEL_DIV48, 8'h01);
		$display("test timer sources done");
		xfer(1'b1, OFS_BAUD, {16'h0, RL, 8'h01});
		xfer(1'b1, OFS_IMASK, 32'h3);
		xfer(1'b1, OFS_CTRL, 32'h10);
		xfer(1'b1, OFS_DATA, 32'ha5);
		fork
			u_far.catch(got, 9);
			u_far.send({2'h1, 9'h13c}, 9);
		join
		chk("tx frame", 32'h1a5, {21'h0, got});
		chk_irq(1'b1);
		rd("control", OFS_CTRL, 32'h57);
		rd("rx data", OFS_DATA, 32'h3c);
		rd("status", OFS_ISTAT, 32'h3);
		rd("status", OFS_ISTAT, 32'h0);
		rd("control", OFS_CTRL, 32'h57);
		u_far.send({2'h1, 9'h177}, 9);
		rd("overrun", OFS_DATA, 32'h3c);
		$display("test duplex done");
		xfer(1'b1, OFS_CTRL, 32'hb8);
		rd("status", OFS_ISTAT, 32'h0);
		xfer(1'b1, OFS_DATA, 32'h5e);
		fork
			u_far.catch(got, 10);
			u_far.send({2'h2, 9'h011}, 10);
		join
		chk("tx nine", 32'h35e, {21'h0, got});
		u_far.send({2'h1, 9'h122}, 10);
		rd("control", OFS_CTRL, 32'hff);
		rd("rx nine", OFS_DATA, 32'h22);
		$display("test nine bit done");
		xfer(1'b1, OFS_CTRL, 32'h10);
		rd("status", OFS_ISTAT, 32'h3);
		xfer(1'b1, OFS_IMASK, 32'h0);
		xfer(1'b1, OFS_DATA, 32'h00);
		u_far.catch(got, 9);
		chk("tx zero", 32'h100, {21'h0, got});
		chk_irq(1'b0);
		xfer(1'b1, OFS_IMASK, 32'h2);
		chk_irq(1'b1);
		rd("status", OFS_ISTAT, 32'h2);
		chk_irq(1'b0);
		rd("control", OFS_CTRL, 32'h52);
		$display("test mask done");
		end_of_test();
	end
endmodule : async_serial_port_baud_gen_test
`default_nettype wire
